// [logic/mcr_common_regs.sv]
// Common control and status register bank of the line mapper
`timescale 1ns/1ps
// Summary of operation
// - Writing one to snapshot bit latches live counters into holding copy.
// - State reset bit holds all state machines at their defaults.
// - Global reset bit restores registers and state machines, self-clears.
// - Host-side loopback returns MII transmit data to receive, PHY only.
// - Line loops post and pre framer; legal only with equal line clocks.
// - Two-bit pin mode picks open-drain, open-source or driven polarity.
// - Read-only four-bit silicon revision equals management revision bits.
// - Five-bit management address resets to 1b, selects served frames.
// - Protection status is OR of unmasked K1, K2, K1-unstable flags.
// - Summary status is any unmasked alarm in an unmasked group.
// - Transport summary ORs six section and line delta flags, gated.
// - Pointer and path summaries OR their unmasked delta flags.
// - Ethernet summary ORs enabled new-event error flags.
// - Merge bit lets protection interrupts also raise summary status.
// - Gate bits, reset one, enable the protection and main pins.
// - Isolate bit tristates MII outputs and ignores MII inputs.
// - Mode bits select SDH, PHY role and GFP encapsulation.
// - Set group mask bits keep a group out of summary status.
// - Line bits force unequipped payload, disable scrambler, descrambler.
// - Each direction bit sets a pin pair as outputs; reset inputs.
// - Sixteen data bits in two byte registers, reset to ones.
// - Registers reachable from management, processor and loader ports.
// - Defaults apply on hardware reset and on software reset.
module mcr_common_regs
  import mcr_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter logic [3:0] SILICON_REV = 4'h0 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mcr_pkg::DATA_W-1:0] reg_wdata,
  output logic [mcr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [CNT_W-1:0] perf_counters_live,
  output logic [CNT_W-1:0] perf_counters_held,
  input wire logic [5:0] transport_flags,
  input wire logic [5:0] transport_flag_masks,
  input wire logic [1:0] pointer_flags,
  input wire logic [1:0] pointer_flag_masks,
  input wire logic [5:0] path_flags,
  input wire logic [5:0] path_flag_masks,
  input wire logic [8:0] ethernet_new_events,
  input wire logic [8:0] ethernet_event_enables,
  input wire logic k1_change_flag,
  input wire logic k2_change_flag,
  input wire logic k1_unstable_flag,
  input wire logic [2:0] protection_flag_masks,
  output logic state_machine_reset,
  output logic register_reset,
  output logic host_side_loopback,
  output logic line_loop_post_framer,
  output logic line_loop_pre_framer,
  output logic sda_pullup_off,
  output logic scl_pullup_off,
  output logic [3:0] silicon_rev_field,
  output logic [4:0] mgmt_station_addr,
  output logic mii_isolate,
  output logic mode_sdh,
  output logic mode_phy,
  output logic mode_gfp,
  output logic send_unequipped_payload,
  output logic line_scrambler_off,
  output logic line_descrambler_off,
  output logic main_irq_pin_o,
  output logic main_irq_pin_oe,
  output logic protection_irq_pin_o,
  output logic protection_irq_pin_oe,
  input wire logic [15:0] gio_pin_i,
  output logic [15:0] gio_pin_o,
  output logic [15:0] gio_pin_oe
);
  import mcr_pkg::*;

  logic snapshot_r;
  logic state_reset_r;
  logic global_reset_r;
  logic [7:0] test_r;
  logic [7:0] pin_cfg_r;
  logic [4:0] mgmt_addr_r;
  logic [7:0] irq_masks_r;
  logic [7:0] mode_r;
  logic [7:0] group_masks_r;
  logic [7:0] line_cfg_r;
  logic [7:0] gio_dir_r;
  logic [15:0] gio_data_r;
  logic [15:0] gio_meta_r;
  logic [15:0] gio_sync_r;
  logic [CNT_W-1:0] held_r;
  logic [7:0] rdata_r;
  logic soft_clear;
  logic [15:0] pair_out;
  logic transport_oh_summary;
  logic pointer_summary;
  logic path_oh_summary;
  logic ethernet_event_summary;
  logic protection_irq_status;
  logic summary_irq_status;
  logic main_active;
  logic prot_active;
  logic [7:0] group_summary;
  logic [7:0] irq_status;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
    hit = reg_wr && (a == ofs);
  endfunction : hit

  function automatic logic [15:0] spread_pairs(input logic [7:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[2*i] = d[i];
      r[2*i+1] = d[i];
    end
    spread_pairs = r;
  endfunction : spread_pairs

  // A one-cycle pulse resets the bank like a hard reset, except read data and pin sync flops
  assign soft_clear = !rst_n || global_reset_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_reset_r <= 1'b0;
    end else begin
      global_reset_r <= hit(reg_addr, OFS_RESET_LATCH)
        && reg_wdata[BIT_GLOBAL_RESET]
        && !global_reset_r;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      state_reset_r <= RST_CTRL[BIT_STATE_RESET];
    end else if (hit(reg_addr, OFS_RESET_LATCH)) begin
      state_reset_r <= reg_wdata[BIT_STATE_RESET];
    end
  end

  // Stored bit only reads back; the copy fires on the write itself
  always_ff @(posedge clk) begin
    if (soft_clear) begin
      snapshot_r <= RST_CTRL[BIT_COUNTER_SNAPSHOT];
    end else if (hit(reg_addr, OFS_RESET_LATCH)) begin
      snapshot_r <= reg_wdata[BIT_COUNTER_SNAPSHOT];
    end
  end

  // Snapshot keeps counter bytes coherent across several reads
  always_ff @(posedge clk) begin
    if (soft_clear) begin
      held_r <= '0;
    end else if (hit(reg_addr, OFS_RESET_LATCH)
                 && reg_wdata[BIT_COUNTER_SNAPSHOT]) begin
      held_r <= perf_counters_live;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      test_r <= RST_TEST;
    end else if (hit(reg_addr, OFS_TEST_LOOP)) begin
      test_r <= reg_wdata & WM_TEST;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      pin_cfg_r <= RST_PIN_CFG;
    end else if (hit(reg_addr, OFS_IRQ_PIN_CFG)) begin
      pin_cfg_r <= reg_wdata & WM_PIN_CFG;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      mgmt_addr_r <= RST_MGMT_ADDR;
    end else if (hit(reg_addr, OFS_MGMT_ADDR)) begin
      mgmt_addr_r <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      irq_masks_r <= RST_IRQ_MASKS;
    end else if (hit(reg_addr, OFS_IRQ_MASKS)) begin
      irq_masks_r <= reg_wdata & WM_IRQ_MASKS;
    end
  end

  // Unguarded write; changing mode outside state reset is unsafe
  always_ff @(posedge clk) begin
    if (soft_clear) begin
      mode_r <= RST_MODE;
    end else if (hit(reg_addr, OFS_MODE_SELECT)) begin
      mode_r <= reg_wdata & WM_MODE;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      group_masks_r <= RST_GROUP_MASKS;
    end else if (hit(reg_addr, OFS_GROUP_MASKS)) begin
      group_masks_r <= reg_wdata & WM_GROUP_MASKS;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      line_cfg_r <= RST_LINE_CFG;
    end else if (hit(reg_addr, OFS_LINE_CFG)) begin
      line_cfg_r <= reg_wdata & WM_LINE_CFG;
    end
  end

  // One direction bit per pin pair
  always_ff @(posedge clk) begin
    if (soft_clear) begin
      gio_dir_r <= RST_GIO_DIR;
    end else if (hit(reg_addr, OFS_GIO_DIR)) begin
      gio_dir_r <= reg_wdata;
    end
  end

  assign pair_out = spread_pairs(gio_dir_r);

  // Writes land only in bits whose pair currently drives
  always_ff @(posedge clk) begin
    if (soft_clear) begin
      gio_data_r <= RST_GIO_DATA;
    end else if (hit(reg_addr, OFS_GIO_LOW)) begin
      gio_data_r[7:0] <= (reg_wdata & pair_out[7:0])
        | (gio_data_r[7:0] & ~pair_out[7:0]);
    end else if (hit(reg_addr, OFS_GIO_HIGH)) begin
      gio_data_r[15:8] <= (reg_wdata & pair_out[15:8])
        | (gio_data_r[15:8] & ~pair_out[15:8]);
    end
  end

  // Pins are asynchronous: two flops before any reader
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gio_meta_r <= '0;
      gio_sync_r <= '0;
    end else begin
      gio_meta_r <= gio_pin_i;
      gio_sync_r <= gio_meta_r;
    end
  end

  assign gio_pin_o = gio_data_r;
  assign gio_pin_oe = pair_out;

  assign transport_oh_summary =
    |(transport_flags & ~transport_flag_masks);
  assign pointer_summary = |(pointer_flags & ~pointer_flag_masks);
  assign path_oh_summary = |(path_flags & ~path_flag_masks);
  assign ethernet_event_summary =
    |(ethernet_new_events & ethernet_event_enables);
  assign protection_irq_status =
    |({k1_change_flag, k2_change_flag, k1_unstable_flag}
      & ~protection_flag_masks);
  assign summary_irq_status =
    (transport_oh_summary && !group_masks_r[BIT_TOH_SUM])
    || (pointer_summary && !group_masks_r[BIT_PTR_SUM])
    || (path_oh_summary && !group_masks_r[BIT_POH_SUM])
    || (ethernet_event_summary && !group_masks_r[BIT_EOS_SUM])
    || (irq_masks_r[BIT_MERGE_PROT] && protection_irq_status);

  always_comb begin
    group_summary = '0;
    group_summary[BIT_TOH_SUM] = transport_oh_summary;
    group_summary[BIT_PTR_SUM] = pointer_summary;
    group_summary[BIT_POH_SUM] = path_oh_summary;
    group_summary[BIT_EOS_SUM] = ethernet_event_summary;
    irq_status = {6'h00, protection_irq_status, summary_irq_status};
  end

  // Mask bits read as enables; the set state lets the pin assert
  assign main_active = summary_irq_status && irq_masks_r[BIT_SUM_GATE];
  assign prot_active =
    protection_irq_status && irq_masks_r[BIT_PROT_GATE];

  // Open-source mode kept for completeness, though not advised
  always_comb begin
    unique case (mcr_pin_mode_type'(pin_cfg_r[1:0]))
      MCR_PIN_OPEN_DRAIN_LOW: begin
        main_irq_pin_o = 1'b0;
        main_irq_pin_oe = main_active;
        protection_irq_pin_o = 1'b0;
        protection_irq_pin_oe = prot_active;
      end
      MCR_PIN_OPEN_SOURCE_HIGH: begin
        main_irq_pin_o = 1'b1;
        main_irq_pin_oe = main_active;
        protection_irq_pin_o = 1'b1;
        protection_irq_pin_oe = prot_active;
      end
      MCR_PIN_DRIVEN_LOW: begin
        main_irq_pin_o = !main_active;
        main_irq_pin_oe = 1'b1;
        protection_irq_pin_o = !prot_active;
        protection_irq_pin_oe = 1'b1;
      end
      MCR_PIN_DRIVEN_HIGH: begin
        main_irq_pin_o = main_active;
        main_irq_pin_oe = 1'b1;
        protection_irq_pin_o = prot_active;
        protection_irq_pin_oe = 1'b1;
      end
    endcase
  end

  // One read path serves every access port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_RESET_LATCH: rdata_r <= {4'h0, snapshot_r, state_reset_r,
                                     2'b00};
        OFS_TEST_LOOP: rdata_r <= test_r;
        OFS_IRQ_PIN_CFG: rdata_r <= pin_cfg_r;
        OFS_SILICON_REV: rdata_r <= {4'h0, SILICON_REV};
        OFS_MGMT_ADDR: rdata_r <= {3'b000, mgmt_addr_r};
        OFS_IRQ_STATUS: rdata_r <= irq_status;
        OFS_GROUP_SUMMARY: rdata_r <= group_summary;
        OFS_IRQ_MASKS: rdata_r <= irq_masks_r;
        OFS_MODE_SELECT: rdata_r <= mode_r;
        OFS_GROUP_MASKS: rdata_r <= group_masks_r;
        OFS_LINE_CFG: rdata_r <= line_cfg_r;
        OFS_GIO_DIR: rdata_r <= gio_dir_r;
        OFS_GIO_LOW: rdata_r <= (gio_data_r[7:0] & pair_out[7:0])
          | (gio_sync_r[7:0] & ~pair_out[7:0]);
        OFS_GIO_HIGH: rdata_r <= (gio_data_r[15:8] & pair_out[15:8])
          | (gio_sync_r[15:8] & ~pair_out[15:8]);
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign perf_counters_held = held_r;
  assign state_machine_reset = state_reset_r || soft_clear;
  assign register_reset = soft_clear;
  // Role gate keeps MAC mode from looping host data
  assign host_side_loopback =
    test_r[BIT_HOST_LOOP] && mode_r[BIT_PHY];
  // Line loops assume equal line clocks; nothing checks that here
  assign line_loop_post_framer = test_r[BIT_LOOP_POST];
  assign line_loop_pre_framer = test_r[BIT_LOOP_PRE];
  assign sda_pullup_off = pin_cfg_r[BIT_SDA_PU_OFF];
  assign scl_pullup_off = pin_cfg_r[BIT_SCL_PU_OFF];
  // One parameter feeds both views so they never disagree
  assign silicon_rev_field = SILICON_REV;
  assign mgmt_station_addr = mgmt_addr_r;
  assign mii_isolate = mode_r[BIT_ISOLATE];
  assign mode_sdh = mode_r[BIT_SDH];
  assign mode_phy = mode_r[BIT_PHY];
  assign mode_gfp = mode_r[BIT_GFP];
  assign send_unequipped_payload = line_cfg_r[BIT_UNEQ];
  assign line_scrambler_off = line_cfg_r[BIT_SCR_OFF];
  assign line_descrambler_off = line_cfg_r[BIT_DSCR_OFF];
endmodule : mcr_common_regs

// [logic/mcr_pkg.sv]
// Constants for the mapper common control register bank
package mcr_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam logic [8:0] OFS_RESET_LATCH = 9'h000;
  localparam logic [8:0] OFS_TEST_LOOP = 9'h001;
  localparam logic [8:0] OFS_IRQ_PIN_CFG = 9'h003;
  localparam logic [8:0] OFS_SILICON_REV = 9'h004;
  localparam logic [8:0] OFS_MGMT_ADDR = 9'h005;
  localparam logic [8:0] OFS_IRQ_STATUS = 9'h006;
  localparam logic [8:0] OFS_GROUP_SUMMARY = 9'h007;
  localparam logic [8:0] OFS_IRQ_MASKS = 9'h008;
  localparam logic [8:0] OFS_MODE_SELECT = 9'h009;
  localparam logic [8:0] OFS_GROUP_MASKS = 9'h00a;
  localparam logic [8:0] OFS_LINE_CFG = 9'h00b;
  localparam logic [8:0] OFS_GIO_DIR = 9'h00d;
  localparam logic [8:0] OFS_GIO_LOW = 9'h00e;
  localparam logic [8:0] OFS_GIO_HIGH = 9'h00f;
  // Field positions
  localparam int BIT_GLOBAL_RESET = 0;
  localparam int BIT_STATE_RESET = 2;
  localparam int BIT_COUNTER_SNAPSHOT = 3;
  localparam int BIT_HOST_LOOP = 2;
  localparam int BIT_LOOP_POST = 1;
  localparam int BIT_LOOP_PRE = 0;
  localparam int BIT_MERGE_PROT = 2;
  localparam int BIT_PROT_GATE = 1;
  localparam int BIT_SUM_GATE = 0;
  localparam int BIT_ISOLATE = 3;
  localparam int BIT_SDH = 2;
  localparam int BIT_PHY = 1;
  localparam int BIT_GFP = 0;
  localparam int BIT_TOH_SUM = 7;
  localparam int BIT_PTR_SUM = 5;
  localparam int BIT_POH_SUM = 4;
  localparam int BIT_EOS_SUM = 2;
  localparam int BIT_UNEQ = 5;
  localparam int BIT_SCR_OFF = 2;
  localparam int BIT_DSCR_OFF = 1;
  localparam int BIT_SDA_PU_OFF = 5;
  localparam int BIT_SCL_PU_OFF = 4;
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_PIN_CFG = 8'h00;
  localparam logic [4:0] RST_MGMT_ADDR = 5'h1b;
  localparam logic [7:0] RST_IRQ_MASKS = 8'h07;
  localparam logic [7:0] RST_MODE = 8'h08;
  localparam logic [7:0] RST_GROUP_MASKS = 8'hb4;
  localparam logic [7:0] RST_LINE_CFG = 8'h00;
  localparam logic [7:0] RST_GIO_DIR = 8'h00;
  localparam logic [15:0] RST_GIO_DATA = 16'hffff;
  localparam logic [7:0] WM_TEST = 8'h07;
  localparam logic [7:0] WM_PIN_CFG = 8'h33;
  localparam logic [7:0] WM_IRQ_MASKS = 8'h07;
  localparam logic [7:0] WM_MODE = 8'h0f;
  localparam logic [7:0] WM_GROUP_MASKS = 8'hb4;
  localparam logic [7:0] WM_LINE_CFG = 8'h26;
  // Interrupt pin modes
  typedef enum logic [1:0] {
    MCR_PIN_OPEN_DRAIN_LOW = 2'b00,
    MCR_PIN_OPEN_SOURCE_HIGH = 2'b01,
    MCR_PIN_DRIVEN_LOW = 2'b10,
    MCR_PIN_DRIVEN_HIGH = 2'b11
  } mcr_pin_mode_type;
endpackage : mcr_pkg

// [bench/mcr_common_regs_chk.sv]
// Port-level assertions for the common register bank
`timescale 1ns/1ps
module mcr_common_regs_chk
  import mcr_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter logic [3:0] SILICON_REV = 4'h0 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [mcr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [CNT_W-1:0] perf_counters_live,
  input wire logic [CNT_W-1:0] perf_counters_held,
  input wire logic state_machine_reset,
  input wire logic register_reset,
  input wire logic host_side_loopback,
  input wire logic mode_phy,
  input wire logic [4:0] mgmt_station_addr,
  input wire logic main_irq_pin_o,
  input wire logic main_irq_pin_oe,
  input wire logic [15:0] gio_pin_oe
);
  logic ctl_wr, snap_wr, addr_wr;
  // Soft reset in the same write may clear the copy, so it is excluded
  assign ctl_wr = reg_wr && reg_addr == OFS_RESET_LATCH;
  assign snap_wr = ctl_wr && reg_wdata[3] && !reg_wdata[0];
  assign addr_wr = reg_wr && reg_addr == OFS_MGMT_ADDR;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  snap_taken_a: assert property (
    snap_wr |=> perf_counters_held == $past(perf_counters_live))
    else $error("Snapshot differs from live counters");
  held_stable_a: assert property (
    !$stable(perf_counters_held) |-> $past(snap_wr) || $past(register_reset))
    else $error("Held counters changed without snapshot");
  state_hold_a: assert property (
    ctl_wr && reg_wdata[2] && !reg_wdata[0] |=> state_machine_reset)
    else $error("State reset bit not honoured");
  soft_pulse_a: assert property (
    ctl_wr && reg_wdata[0] |-> ##[1:2] register_reset)
    else $error("Soft reset pulse missing");
  soft_default_a: assert property (
    register_reset |=> mgmt_station_addr == 5'h1b)
    else $error("Address not at default after reset");
  loop_phy_a: assert property (host_side_loopback |-> mode_phy)
    else $error("Host loopback outside PHY role");
  rev_read_a: assert property (
    reg_rd && reg_addr == OFS_SILICON_REV |=> reg_rdata == {4'h0, SILICON_REV})
    else $error("Revision read wrong");
  addr_hold_a: assert property (
    !$stable(mgmt_station_addr) |-> $past(addr_wr) || $past(register_reset))
    else $error("Address changed without write");
  pair_dir_a: assert property (
    ((gio_pin_oe ^ (gio_pin_oe >> 1)) & 16'h5555) == 16'h0000)
    else $error("Pin pair directions differ");
  snap_c: cover property (snap_wr);
  soft_c: cover property (register_reset);
  pin_c: cover property (main_irq_pin_oe && main_irq_pin_o);
endmodule : mcr_common_regs_chk

bind mcr_common_regs mcr_common_regs_chk #(
  .CNT_W(CNT_W), .SILICON_REV(SILICON_REV)
) u_chk (
  .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .perf_counters_live, .perf_counters_held, .state_machine_reset,
  .register_reset, .host_side_loopback, .mode_phy, .mgmt_station_addr,
  .main_irq_pin_o, .main_irq_pin_oe, .gio_pin_oe
);

// [bench/mcr_host_model.sv]
// Host processor model on the parallel register port
`timescale 1ns/1ps
module mcr_host_model
  import mcr_pkg::*;
(
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [mcr_pkg::ADDR_W-1:0] reg_addr,
  output logic [mcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [mcr_pkg::DATA_W-1:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h1ff;
    reg_wdata = 8'h00;
  end
  // Released lines flip so stale values never pass for valid ones
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : mcr_host_model

// [bench/mcr_common_regs_tb.sv]
// Self-checking bench for the common register bank
`timescale 1ns/1ps
module mcr_common_regs_tb;
  import mcr_pkg::*;
  localparam logic [3:0] REV = 4'h6; // Arbitrary value
  logic clk, rst_n, reg_wr, reg_rd, k1_change_flag, k2_change_flag;
  logic k1_unstable_flag, state_machine_reset, register_reset, mode_phy;
  logic host_side_loopback, line_loop_post_framer, line_loop_pre_framer;
  logic sda_pullup_off, scl_pullup_off, mii_isolate, mode_sdh, mode_gfp;
  logic send_unequipped_payload, line_scrambler_off, line_descrambler_off;
  logic main_irq_pin_o, main_irq_pin_oe;
  logic protection_irq_pin_o, protection_irq_pin_oe;
  logic [8:0] reg_addr, ethernet_new_events, ethernet_event_enables;
  logic [7:0] reg_wdata, reg_rdata;
  logic [31:0] perf_counters_live, perf_counters_held;
  logic [5:0] transport_flags, transport_flag_masks, path_flags;
  logic [5:0] path_flag_masks;
  logic [1:0] pointer_flags, pointer_flag_masks;
  logic [2:0] protection_flag_masks;
  logic [3:0] silicon_rev_field;
  logic [4:0] mgmt_station_addr;
  logic [15:0] gio_pin_i, gio_pin_o, gio_pin_oe;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] grp_bit [4] = '{8'h80, 8'h20, 8'h10, 8'h04};

  mcr_common_regs #(.CNT_W(32), .SILICON_REV(REV)) dut (
    .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .perf_counters_live, .perf_counters_held, .transport_flags,
    .transport_flag_masks, .pointer_flags, .pointer_flag_masks, .path_flags,
    .path_flag_masks, .ethernet_new_events, .ethernet_event_enables,
    .k1_change_flag, .k2_change_flag, .k1_unstable_flag,
    .protection_flag_masks, .state_machine_reset, .register_reset,
    .host_side_loopback, .line_loop_post_framer, .line_loop_pre_framer,
    .sda_pullup_off, .scl_pullup_off, .silicon_rev_field, .mgmt_station_addr,
    .mii_isolate, .mode_sdh, .mode_phy, .mode_gfp, .send_unequipped_payload,
    .line_scrambler_off, .line_descrambler_off, .main_irq_pin_o,
    .main_irq_pin_oe, .protection_irq_pin_o, .protection_irq_pin_oe,
    .gio_pin_i, .gio_pin_o, .gio_pin_oe
  );
  mcr_host_model host (
    .clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask : rdc
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic t_defaults();
    rdc(OFS_RESET_LATCH, 8'h00);
    rdc(OFS_TEST_LOOP, 8'h00);
    rdc(OFS_IRQ_PIN_CFG, 8'h00);
    rdc(OFS_SILICON_REV, {4'h0, REV});
    rdc(OFS_MGMT_ADDR, 8'h1b);
    rdc(OFS_IRQ_MASKS, 8'h07);
    rdc(OFS_MODE_SELECT, 8'h08);
    rdc(OFS_GROUP_MASKS, 8'hb4);
    rdc(OFS_LINE_CFG, 8'h00);
    rdc(OFS_GIO_DIR, 8'h00);
    rdc(OFS_GIO_LOW, gio_pin_i[7:0]);
    rdc(OFS_GIO_HIGH, gio_pin_i[15:8]);
    chk({gio_pin_o, gio_pin_oe}, 32'hffff0000);
    chk({mii_isolate, silicon_rev_field}, {1'b1, REV});
    $display("defaults done");
  endtask : t_defaults

  task automatic t_rw();
    host.wr(OFS_TEST_LOOP, 8'hff);
    host.wr(OFS_IRQ_PIN_CFG, 8'hff);
    host.wr(OFS_MGMT_ADDR, 8'hea);
    host.wr(OFS_LINE_CFG, 8'hff);
    host.wr(OFS_SILICON_REV, 8'hff);
    host.wr(OFS_RESET_LATCH, 8'h04);
    host.wr(OFS_MODE_SELECT, 8'h06);
    rdc(OFS_TEST_LOOP, 8'h07);
    rdc(OFS_IRQ_PIN_CFG, 8'h33);
    rdc(OFS_MGMT_ADDR, 8'h0a);
    rdc(OFS_LINE_CFG, 8'h26);
    rdc(OFS_SILICON_REV, {4'h0, REV});
    rdc(OFS_MODE_SELECT, 8'h06);
    rdc(9'h00c, 8'h00);
    chk({state_machine_reset, mgmt_station_addr}, 6'h2a);
    chk({host_side_loopback, line_loop_post_framer, line_loop_pre_framer,
      sda_pullup_off, scl_pullup_off}, 5'h1f);
    chk({mode_sdh, mode_phy, mode_gfp, mii_isolate}, 4'hc);
    chk({send_unequipped_payload, line_scrambler_off,
      line_descrambler_off}, 3'h7);
    host.wr(OFS_MODE_SELECT, 8'h09);
    @(negedge clk);
    chk({host_side_loopback, mode_gfp, mii_isolate, mode_phy}, 4'h6);
    host.wr(OFS_RESET_LATCH, 8'h01);
    @(negedge clk);
    chk({register_reset, state_machine_reset}, 2'b11);
    // Writes right after the soft reset would be overridden
    repeat (3) @(negedge clk);
    chk(state_machine_reset, 1'b0);
    t_defaults();
    $display("read write done");
  endtask : t_rw

  task automatic t_snap();
    @(posedge clk);
    perf_counters_live <= 32'h1234abcd;
    host.wr(OFS_RESET_LATCH, 8'h08);
    @(posedge clk);
    perf_counters_live <= 32'h0badf00d;
    @(negedge clk);
    chk(perf_counters_held, 32'h1234abcd);
    host.wr(OFS_RESET_LATCH, 8'h08);
    @(negedge clk);
    chk(perf_counters_held, 32'h0badf00d);
    $display("snapshot done");
  endtask : t_snap

  task automatic t_irq();
    host.wr(OFS_GROUP_MASKS, 8'h00);
    rdc(OFS_GROUP_SUMMARY, 8'h00);
    rdc(OFS_IRQ_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      transport_flag_masks <= (i == 0) ? 6'h1f : 6'h3f;
      pointer_flag_masks <= (i == 1) ? 2'h1 : 2'h3;
      path_flag_masks <= (i == 2) ? 6'h3e : 6'h3f;
      ethernet_event_enables <= (i == 3) ? 9'h100 : 9'h000;
      rdc(OFS_GROUP_SUMMARY, grp_bit[i]);
      rdc(OFS_IRQ_STATUS, 8'h01);
    end
    host.wr(OFS_GROUP_MASKS, 8'h04);
    rdc(OFS_IRQ_STATUS, 8'h00);
    host.wr(OFS_GROUP_MASKS, 8'h00);
    for (int m = 0; m < 4; m++) begin
      host.wr(OFS_IRQ_PIN_CFG, 8'(m));
      @(negedge clk);
      chk({main_irq_pin_oe, main_irq_pin_o}, {1'b1, m[0]});
    end
    host.wr(OFS_IRQ_MASKS, 8'h06);
    @(negedge clk);
    chk({main_irq_pin_oe, main_irq_pin_o}, 2'b10);
    @(posedge clk);
    ethernet_event_enables <= 9'h000;
    protection_flag_masks <= 3'b011;
    host.wr(OFS_IRQ_MASKS, 8'h07);
    rdc(OFS_IRQ_STATUS, 8'h03);
    chk({protection_irq_pin_oe, protection_irq_pin_o}, 2'b11);
    host.wr(OFS_IRQ_MASKS, 8'h03);
    rdc(OFS_IRQ_STATUS, 8'h02);
    host.wr(OFS_IRQ_MASKS, 8'h05);
    @(negedge clk);
    chk({protection_irq_pin_oe, protection_irq_pin_o}, 2'b10);
    chk({main_irq_pin_oe, main_irq_pin_o}, 2'b11);
    host.wr(OFS_IRQ_PIN_CFG, 8'h00);
    @(negedge clk);
    chk(main_irq_pin_oe, 1'b1);
    $display("interrupt done");
  endtask : t_irq

  task automatic t_gpio();
    host.wr(OFS_GIO_DIR, 8'h81);
    host.wr(OFS_GIO_LOW, 8'h00);
    host.wr(OFS_GIO_HIGH, 8'h00);
    rdc(OFS_GIO_LOW, {gio_pin_i[7:2], 2'b00});
    rdc(OFS_GIO_HIGH, {2'b00, gio_pin_i[13:8]});
    chk({gio_pin_oe, gio_pin_o}, 32'hc0033ffc);
    $display("general io done");
  endtask : t_gpio

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    $display("[ERR] %0t timeout got %h exp %h", $time, 1'b0, 1'b1);
    n_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    {k1_change_flag, k2_change_flag, k1_unstable_flag} = 3'b111;
    protection_flag_masks = 3'b111;
    {transport_flags, transport_flag_masks} = 12'hfff;
    {path_flags, path_flag_masks} = 12'hfff;
    {pointer_flags, pointer_flag_masks} = 4'hf;
    ethernet_new_events = 9'h1ff;
    ethernet_event_enables = 9'h000;
    perf_counters_live = 32'h0;
    gio_pin_i = 16'ha5c3;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_rw();
    t_snap();
    t_irq();
    t_gpio();
    print_verdict();
  end
endmodule : mcr_common_regs_tb
